// ==== hdl/gpio_irq_pkg.sv ====
// Package for the per-pin interrupt logic of ports A, B and F.
// Assumes a 32-bit AXI4-Lite register bus and a 50 MHz system clock.
package gpio_irq_pkg;
   localparam int PORTS = 3;
   localparam int PINS = 8;
   localparam int ADDR_W = 32;
   // Register byte addresses.
   localparam logic [31:0] F_KIND_ADDR = 32'h8084004C;
   localparam logic [31:0] F_POL_ADDR = 32'h80840050;
   localparam logic [31:0] F_CLR_ADDR = 32'h80840054;
   localparam logic [31:0] F_EN_ADDR = 32'h80840058;
   localparam logic [31:0] F_MASK_ADDR = 32'h8084005C;
   localparam logic [31:0] F_RAW_ADDR = 32'h80840060;
   localparam logic [31:0] F_DB_ADDR = 32'h80840064;
   localparam logic [31:0] A_KIND_ADDR = 32'h80840090;
   localparam logic [31:0] A_POL_ADDR = 32'h80840094;
   localparam logic [31:0] A_CLR_ADDR = 32'h80840098;
   localparam logic [31:0] A_EN_ADDR = 32'h8084009C;
   localparam logic [31:0] A_MASK_ADDR = 32'h808400A0;
   localparam logic [31:0] A_RAW_ADDR = 32'h808400A4;
   localparam logic [31:0] A_DB_ADDR = 32'h808400A8;
   localparam logic [31:0] B_KIND_ADDR = 32'h808400AC;
   localparam logic [31:0] B_POL_ADDR = 32'h808400B0;
   localparam logic [31:0] B_CLR_ADDR = 32'h808400B4;
   localparam logic [31:0] B_EN_ADDR = 32'h808400B8;
   localparam logic [31:0] B_MASK_ADDR = 32'h808400BC;
   localparam logic [31:0] B_RAW_ADDR = 32'h808400C0;
   localparam logic [31:0] B_DB_ADDR = 32'h808400C4;
   localparam logic [31:0] DRV_ADDR = 32'h808400C8;
   // Driver-type register fields.
   localparam int DRV_CLK_BIT = 0;
   localparam int DRV_DAT_BIT = 1;
   // Reset values.
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [1:0] DRV_RESET = 2'h0;
   // AXI responses.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Debounce tick derived from the system clock.
   localparam int CLOCK_HZ = 50000000;
   localparam int DEBOUNCE_HZ = 128;
   localparam int DEBOUNCE_DIV = CLOCK_HZ / DEBOUNCE_HZ;

   typedef struct packed {
      logic [7:0] kind;
      logic [7:0] pol;
      logic [7:0] en;
      logic [7:0] db;
   } port_cfg_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } wr_req_t;
endpackage

// ==== hdl/gpio_irq.sv ====
// Pin interrupt logic for ports A, B and F with an AXI4-Lite slave.
// Assumes pins arrive asynchronously and the direction register lives
// elsewhere; its bits are taken in on pin_dir.
//
// Behaviour
// - Kind bit: 0 level, 1 edge
// - Polarity bit: 1 rising/high, 0 falling/low
// - Reset clears kind and polarity registers
// - Writing 1 to clear register clears edge
// - Disabling interrupt mode clears pin interrupt
// - Debounce bit enables pin debouncing
// - Debounce through two stages at 128 Hz
// - Raw status ignores enable; edge raw status is cleared here while its enable bit is 0
// - Level raw status follows active pin level
// - Edge raw status latches until cleared
// - Debounced input feeds raw status
// - Masked status is raw gated by enable
// - Only low eight bits carry fields
// - Driver bit set means open drain
// - Bit 1 data pin, bit 0 clock pin
// - Enable makes pin an interrupt source
// - Reset leaves low-level sensitivity
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module gpio_irq
   import gpio_irq_pkg::*;
(
   // Clock and reset.
   input wire logic clock,
   input wire logic reset_n,
   // AXI4-Lite write address.
   input wire logic [gpio_irq_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   // AXI4-Lite write data.
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // AXI4-Lite write response.
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read.
   input wire logic [gpio_irq_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Port pins, index 0 = A, 1 = B, 2 = F.
   input wire logic [2:0][7:0] pin_in,
   input wire logic [2:0][7:0] pin_dir,
   // Per-port interrupt requests.
   output logic [2:0] port_irq,
   // Serial ROM pins, driven by the ROM interface elsewhere.
   input wire logic rom_clock_drive,
   input wire logic rom_data_drive,
   output logic rom_clock_pin_out,
   output logic rom_clock_pin_oe,
   output logic rom_data_pin_out,
   output logic rom_data_pin_oe
);
   import gpio_irq_pkg::*;

   port_cfg_t cfg_r [PORTS];
   logic [7:0] raw_r [PORTS];
   logic [7:0] sync1_r [PORTS];
   logic [7:0] sync2_r [PORTS];
   logic [7:0] sync3_r [PORTS];
   logic [7:0] stable_r [PORTS];
   logic [7:0] db1_r [PORTS];
   logic [7:0] db2_r [PORTS];
   logic [7:0] prev_r [PORTS];
   logic [7:0] clr_nxt [PORTS];
   logic [7:0] pin_eff [PORTS];
   logic [7:0] masked [PORTS];
   logic [1:0] drv_r;
   logic [25:0] tick_cnt_r;
   logic tick;

   // Write channel state.
   wr_req_t wr_r;
   logic aw_have_r;
   logic w_have_r;
   logic do_write;

   // 128 Hz debounce tick from the system clock.
   always_ff @(posedge clock)
   begin
      if (!reset_n)
         tick_cnt_r <= '0;
      else if (tick)
         tick_cnt_r <= '0;
      else
         tick_cnt_r <= tick_cnt_r + 26'h0000001;
   end
   assign tick = (tick_cnt_r == 26'(DEBOUNCE_DIV - 1));

   // Write address and data are accepted in either order.
   assign awready = !aw_have_r && !bvalid;
   assign wready = !w_have_r && !bvalid;
   assign do_write = aw_have_r && w_have_r && !bvalid;

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         wr_r <= '0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end
      else
      begin
         if (awvalid && awready)
         begin
            aw_have_r <= 1'b1;
            wr_r.addr <= awaddr;
         end
         if (wvalid && wready)
         begin
            w_have_r <= 1'b1;
            wr_r.data <= wdata;
            wr_r.strb <= wstrb;
         end
         if (do_write)
         begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            bvalid <= 1'b1;
            bresp <= addr_ok(wr_r.addr, 1'b1) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (bvalid && bready)
            bvalid <= 1'b0;
      end
   end

   // Index of the port whose registers an address hits, 3 if none.
   function automatic logic [1:0] port_of(input logic [31:0] a);
      logic [1:0] p;
      p = 2'h3;
      if (a >= F_KIND_ADDR && a <= F_DB_ADDR)
         p = 2'h2;
      if (a >= A_KIND_ADDR && a <= A_DB_ADDR)
         p = 2'h0;
      if (a >= B_KIND_ADDR && a <= B_DB_ADDR)
         p = 2'h1;
      return p;
   endfunction

   // Word offset within a port block, counted from its kind register.
   function automatic logic [2:0] slot_of(input logic [31:0] a);
      logic [31:0] base;
      base = A_KIND_ADDR;
      case (port_of(a))
         2'h1: base = B_KIND_ADDR;
         2'h2: base = F_KIND_ADDR;
         default: base = A_KIND_ADDR;
      endcase
      return 3'((a - base) >> 2);
   endfunction

   function automatic logic addr_ok(input logic [31:0] a, input logic wr);
      logic ok;
      ok = (a[1:0] == 2'h0) && ((port_of(a) != 2'h3) || a == DRV_ADDR);
      // Status registers take no writes.
      if (wr && port_of(a) != 2'h3 && slot_of(a) >= 3'h4 &&
          slot_of(a) != 3'h6)
         ok = 1'b0;
      return ok;
   endfunction

   // Configuration registers; only the low byte lane is stored.
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         for (int p = 0; p < PORTS; p++)
            cfg_r[p] <= {CFG_RESET, CFG_RESET, CFG_RESET, CFG_RESET};
         drv_r <= DRV_RESET;
      end
      else if (do_write && addr_ok(wr_r.addr, 1'b1) && wr_r.strb[0])
      begin
         if (wr_r.addr == DRV_ADDR)
            drv_r <= wr_r.data[1:0];
         else
            for (int p = 0; p < PORTS; p++)
               if (port_of(wr_r.addr) == 2'(p))
                  case (slot_of(wr_r.addr))
                     3'h0: cfg_r[p].kind <= wr_r.data[7:0];
                     3'h1: cfg_r[p].pol <= wr_r.data[7:0];
                     3'h3: cfg_r[p].en <= wr_r.data[7:0];
                     3'h6: cfg_r[p].db <= wr_r.data[7:0];
                     default: ;
                  endcase
      end
   end

   // Edge-clear strobes, live for the single write cycle.
   always_comb
   begin
      for (int p = 0; p < PORTS; p++)
      begin
         clr_nxt[p] = 8'h00;
         if (do_write && wr_r.strb[0] && port_of(wr_r.addr) == 2'(p) &&
             slot_of(wr_r.addr) == 3'h2)
            clr_nxt[p] = wr_r.data[7:0];
      end
   end

   // Pin synchronisers, a two-sample agreement filter and the debounce chain.
   always_ff @(posedge clock)
   begin
      for (int p = 0; p < PORTS; p++)
      begin
         sync1_r[p] <= pin_in[p];
         sync2_r[p] <= sync1_r[p];
         sync3_r[p] <= sync2_r[p];
      end
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
         for (int p = 0; p < PORTS; p++)
         begin
            stable_r[p] <= 8'h00;
            db1_r[p] <= 8'h00;
            db2_r[p] <= 8'h00;
         end
      else
         for (int p = 0; p < PORTS; p++)
         begin
            for (int i = 0; i < PINS; i++)
               if (sync2_r[p][i] == sync3_r[p][i])
                  stable_r[p][i] <= sync3_r[p][i];
            if (tick)
            begin
               db1_r[p] <= stable_r[p];
               db2_r[p] <= db1_r[p];
            end
         end
   end

   always_comb
   begin
      for (int p = 0; p < PORTS; p++)
         for (int i = 0; i < PINS; i++)
            pin_eff[p][i] = cfg_r[p].db[i] ? db2_r[p][i] : stable_r[p][i];
   end

   // Raw status: level follows the pin, edge latches until cleared.
   always_ff @(posedge clock)
   begin
      if (!reset_n)
         for (int p = 0; p < PORTS; p++)
         begin
            raw_r[p] <= 8'h00;
            prev_r[p] <= 8'h00;
         end
      else
         for (int p = 0; p < PORTS; p++)
         begin
            prev_r[p] <= pin_eff[p];
            for (int i = 0; i < PINS; i++)
            begin
               if (!cfg_r[p].kind[i])
                  raw_r[p][i] <= pin_eff[p][i] == cfg_r[p].pol[i];
               else if (cfg_r[p].pol[i] ? (pin_eff[p][i] && !prev_r[p][i])
                                         : (!pin_eff[p][i] && prev_r[p][i]))
                  raw_r[p][i] <= 1'b1;
               else if (clr_nxt[p][i] || !cfg_r[p].en[i])
                  raw_r[p][i] <= 1'b0;
            end
         end
   end

   always_comb
   begin
      for (int p = 0; p < PORTS; p++)
         masked[p] = raw_r[p] & cfg_r[p].en;
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
         port_irq <= 3'h0;
      else
         for (int p = 0; p < PORTS; p++)
            port_irq[p] <= |masked[p];
   end

   // Read channel: one-cycle answer, reserved bits read zero.
   assign arready = !rvalid;

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         rvalid <= 1'b1;
         rresp <= addr_ok(araddr, 1'b0) ? RESP_OKAY : RESP_SLVERR;
         rdata <= 32'h00000000;
         if (araddr == DRV_ADDR)
            rdata <= {30'h00000000, drv_r};
         for (int p = 0; p < PORTS; p++)
            if (port_of(araddr) == 2'(p))
               case (slot_of(araddr))
                  3'h0: rdata <= {24'h000000, cfg_r[p].kind};
                  3'h1: rdata <= {24'h000000, cfg_r[p].pol};
                  3'h3: rdata <= {24'h000000, cfg_r[p].en};
                  3'h4: rdata <= {24'h000000, masked[p]};
                  3'h5: rdata <= {24'h000000, raw_r[p]};
                  3'h6: rdata <= {24'h000000, cfg_r[p].db};
                  default: rdata <= 32'h00000000;
               endcase
      end
      else if (rvalid && rready)
         rvalid <= 1'b0;
   end

   // Serial ROM pins: open drain drives only a low level.
   assign rom_clock_pin_out = rom_clock_drive;
   assign rom_clock_pin_oe = drv_r[DRV_CLK_BIT] ? !rom_clock_drive : 1'b1;
   assign rom_data_pin_out = rom_data_drive;
   assign rom_data_pin_oe = drv_r[DRV_DAT_BIT] ? !rom_data_drive : 1'b1;

   // The raw bit is judged against the inputs of the cycle before, so a
   // polarity write or a pin change in between does not trip the check.
   chk_level_follow: assert property (
      @(posedge clock) disable iff (!reset_n)
      !cfg_r[0].kind[0] && $stable(cfg_r[0]) && $stable(pin_eff[0][0])
      |=> raw_r[0][0] == ($past(pin_eff[0][0]) == $past(cfg_r[0].pol[0])))
      else $error("level raw status wrong");
   chk_edge_hold: assert property (
      @(posedge clock) disable iff (!reset_n)
      cfg_r[1].kind[2] && raw_r[1][2] && !clr_nxt[1][2] && cfg_r[1].en[2]
      && $stable(cfg_r[1].kind) |=> raw_r[1][2])
      else $error("edge status dropped");
   chk_edge_clear: assert property (
      @(posedge clock) disable iff (!reset_n)
      cfg_r[2].kind[3] && clr_nxt[2][3] && $stable(cfg_r[2].kind)
      && !(cfg_r[2].pol[3] ? (pin_eff[2][3] && !prev_r[2][3])
                           : (!pin_eff[2][3] && prev_r[2][3]))
      |=> !raw_r[2][3])
      else $error("edge clear ignored");
   // Watches the value that actually leaves on the read channel.
   chk_mask_gate: assert property (
      @(posedge clock) disable iff (!reset_n)
      $rose(rvalid) && $past(araddr) == A_MASK_ADDR
      |-> rdata[7:0] == ($past(raw_r[0]) & $past(cfg_r[0].en)))
      else $error("masked status wrong");
   chk_irq_any: assert property (
      @(posedge clock) disable iff (!reset_n)
      (|masked[1]) |=> port_irq[1])
      else $error("port request missing");
   chk_reset_cfg: assert property (
      @(posedge clock)
      !reset_n |=> cfg_r[2].kind == 8'h00 && cfg_r[2].pol == 8'h00)
      else $error("type regs not reset");
   chk_debounce_src: assert property (
      @(posedge clock) disable iff (!reset_n)
      cfg_r[2].db[0] && !cfg_r[2].kind[0]
      |=> raw_r[2][0] == ($past(db2_r[2][0]) == $past(cfg_r[2].pol[0])))
      else $error("debounce not used");
   chk_disable_clear: assert property (
      @(posedge clock) disable iff (!reset_n)
      cfg_r[1].kind[0] && !cfg_r[1].en[0] && $stable(cfg_r[1].kind)
      && !(cfg_r[1].pol[0] ? (pin_eff[1][0] && !prev_r[1][0])
                           : (!pin_eff[1][0] && prev_r[1][0]))
      |=> !raw_r[1][0])
      else $error("disabled edge not cleared");
   chk_open_drain: assert property (
      @(posedge clock) disable iff (!reset_n)
      drv_r[DRV_DAT_BIT] && rom_data_drive |-> !rom_data_pin_oe)
      else $error("open drain drives high");
endmodule

// ==== test/pin_model.sv ====
// Model of the external pins of ports A, B and F and of the ROM pins.
// Assumes the bench changes pin levels through set_pins after an edge.
`timescale 1ns/10ps
module pin_model
(
   // Pin levels toward the design.
   output logic [2:0][7:0] pin_in,
   output logic [2:0][7:0] pin_dir,
   // ROM pin drivers from the design.
   input wire logic clk_out,
   input wire logic clk_oe,
   input wire logic dat_out,
   input wire logic dat_oe,
   // Resolved ROM wire levels.
   output logic clk_level,
   output logic dat_level
);
   initial
   begin
      pin_in = '0;
      pin_dir = '0;
   end
   // A released ROM wire is pulled up, so it never keeps the last value.
   assign clk_level = clk_oe ? clk_out : 1'b1;
   assign dat_level = dat_oe ? dat_out : 1'b1;
   task automatic set_pins(input int p, input logic [7:0] v);
      pin_in[p] <= v;
   endtask
endmodule

// ==== test/gpio_irq_test.sv ====
// Self-checking bench for the pin interrupt block and its register bus.
// Assumes the pin model stands in for the pins and the ROM wires.
`timescale 1ns/10ps
module gpio_irq_test;
   import gpio_irq_pkg::*;
   typedef logic [31:0] word_t;
   localparam word_t KIND_A [3] = '{A_KIND_ADDR, B_KIND_ADDR, F_KIND_ADDR};
   localparam word_t POL_A [3] = '{A_POL_ADDR, B_POL_ADDR, F_POL_ADDR};
   localparam word_t CLR_A [3] = '{A_CLR_ADDR, B_CLR_ADDR, F_CLR_ADDR};
   localparam word_t EN_A [3] = '{A_EN_ADDR, B_EN_ADDR, F_EN_ADDR};
   localparam word_t MASK_A [3] = '{A_MASK_ADDR, B_MASK_ADDR, F_MASK_ADDR};
   localparam word_t RAW_A [3] = '{A_RAW_ADDR, B_RAW_ADDR, F_RAW_ADDR};
   localparam word_t DB_A [3] = '{A_DB_ADDR, B_DB_ADDR, F_DB_ADDR};
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
   logic [3:0] wstrb = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, resp;
   logic [2:0][7:0] pin_in, pin_dir;
   logic [2:0] port_irq;
   logic clk_drive = 1'b0, dat_drive = 1'b0;
   logic clk_out, clk_oe, dat_out, dat_oe, clk_level, dat_level;
   int n_mismatch = 0;
   int comparisons = 0;

   gpio_irq u_dut (.clock(clock), .reset_n(reset_n), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .pin_in(pin_in), .pin_dir(pin_dir),
      .port_irq(port_irq), .rom_clock_drive(clk_drive),
      .rom_data_drive(dat_drive), .rom_clock_pin_out(clk_out),
      .rom_clock_pin_oe(clk_oe), .rom_data_pin_out(dat_out),
      .rom_data_pin_oe(dat_oe));
   pin_model u_pins (.pin_in(pin_in), .pin_dir(pin_dir), .clk_out(clk_out),
      .clk_oe(clk_oe), .dat_out(dat_out), .dat_oe(dat_oe),
      .clk_level(clk_level), .dat_level(dat_level));

   always #10 clock = ~clock;

   task automatic check(input word_t seen, input word_t exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Address and data go out together; each is dropped once taken.
   // Only the watchdog ends a wait for the response.
   task automatic wr(input word_t a, input word_t d, output logic [1:0] r);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (awvalid === 1'b1 && awready === 1'b1)
            awvalid <= 1'b0;
         if (wvalid === 1'b1 && wready === 1'b1)
            wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
      @(posedge clock);
   endtask

   task automatic rd(input word_t a, output word_t d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (arvalid === 1'b1 && arready === 1'b1)
            arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge clock);
   endtask

   task automatic rd_chk(input word_t a, input word_t exp);
      word_t d;
      logic [1:0] r;
      rd(a, d, r);
      check(d, exp);
   endtask

   task automatic set_wait(input int p, input logic [7:0] v);
      u_pins.set_pins(p, v);
      repeat (10) @(posedge clock);
   endtask

   task automatic test_reset;
      word_t d;
      for (int p = 0; p < 3; p++)
      begin
         rd_chk(KIND_A[p], 32'h0);
         rd_chk(POL_A[p], 32'h0);
         rd_chk(DB_A[p], 32'h0);
         rd_chk(RAW_A[p], 32'hFF);
         rd_chk(MASK_A[p], 32'h0);
      end
      rd_chk(DRV_ADDR, 32'h0);
      rd(32'h80840068, d, resp);
      check({30'h0, resp}, {30'h0, RESP_SLVERR});
      wr(A_RAW_ADDR, 32'hFF, resp);
      check({30'h0, resp}, {30'h0, RESP_SLVERR});
      wr(B_KIND_ADDR, 32'hFFFFFF00, resp);
      rd_chk(B_KIND_ADDR, 32'h0);
   endtask

   task automatic test_level(input int p);
      wr(POL_A[p], 32'hFF, resp);
      set_wait(p, 8'h5A);
      rd_chk(RAW_A[p], 32'h5A);
      wr(EN_A[p], 32'h0F, resp);
      rd_chk(RAW_A[p], 32'h5A);
      rd_chk(MASK_A[p], 32'h0A);
      check({31'h0, port_irq[p]}, 32'h1);
      wr(POL_A[p], 32'h00, resp);
      rd_chk(RAW_A[p], 32'hA5);
      wr(EN_A[p], 32'h00, resp);
      rd_chk(MASK_A[p], 32'h0);
      check({31'h0, port_irq[p]}, 32'h0);
      set_wait(p, 8'h00);
   endtask

   task automatic test_edge(input int p);
      // Kind is set before polarity so the polarity has meaning.
      wr(KIND_A[p], 32'hFF, resp);
      wr(POL_A[p], 32'hFF, resp);
      wr(EN_A[p], 32'hFF, resp);
      wr(CLR_A[p], 32'hFF, resp);
      rd_chk(RAW_A[p], 32'h0);
      set_wait(p, 8'h03);
      set_wait(p, 8'h00);
      rd_chk(RAW_A[p], 32'h03);
      check({31'h0, port_irq[p]}, 32'h1);
      // The service routine clears early so a new edge is kept.
      wr(CLR_A[p], 32'h01, resp);
      rd_chk(RAW_A[p], 32'h02);
      wr(POL_A[p], 32'h00, resp);
      set_wait(p, 8'h84);
      set_wait(p, 8'h00);
      rd_chk(MASK_A[p], 32'h86);
      wr(EN_A[p], 32'h00, resp);
      rd_chk(RAW_A[p], 32'h0);
      wr(KIND_A[p], 32'h00, resp);
      rd_chk(RAW_A[p], 32'hFF);
   endtask

   // The 128 Hz tick lies far past this run, so the filter holds low.
   task automatic test_debounce;
      wr(F_POL_ADDR, 32'hFF, resp);
      wr(F_DB_ADDR, 32'h01, resp);
      rd_chk(F_DB_ADDR, 32'h01);
      set_wait(2, 8'h03);
      rd_chk(F_RAW_ADDR, 32'h02);
      wr(F_DB_ADDR, 32'h00, resp);
      repeat (10) @(posedge clock);
      rd_chk(F_RAW_ADDR, 32'h03);
   endtask

   task automatic test_drive;
      for (int m = 0; m < 4; m++)
      begin
         wr(DRV_ADDR, 32'hFFFFFFFC | m, resp);
         rd_chk(DRV_ADDR, m);
         for (int v = 0; v < 2; v++)
         begin
            clk_drive <= v[0];
            dat_drive <= v[0];
            @(posedge clock);
            #1;
            check(clk_oe, !(m[0] && v[0]));
            check(dat_oe, !(m[1] && v[0]));
            check({clk_level, dat_level}, {2{v[0]}});
            @(posedge clock);
         end
      end
   endtask

   task automatic summarize;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      #(20 * 60000);
      n_mismatch++;
      summarize();
   end

   initial
   begin
      repeat (20) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      test_reset();
      for (int p = 0; p < 3; p++)
      begin
         test_level(p);
         test_edge(p);
      end
      test_debounce();
      test_drive();
      summarize();
   end
endmodule
